// ---- hw/adc_cal_pkg.sv ----
// constants shared by the conversion correction path
package adc_cal_pkg;

  // coefficient registers
  localparam int          COEF_W    = 24;
  localparam logic [23:0] COEF_RST  = 24'h000000;
  // unity gain sits at 2^GAIN_FRAC, so a zero coefficient means 1x
  localparam int          GAIN_FRAC = 23;

  // calibration control register layout
  localparam logic [7:0] CTRL_RST       = 8'h1e;
  localparam logic [7:0] CTRL_WMASK     = 8'hfe;
  localparam int         GAIN_CODE_HI   = 7;
  localparam int         GAIN_CODE_LO   = 5;
  localparam int         SYS_GAIN_BYP   = 4;
  localparam int         SYS_OFF_BYP    = 3;
  localparam int         SELF_GAIN_BYP  = 2;
  localparam int         SELF_OFF_BYP   = 1;
  localparam logic [2:0] GAIN_CODE_MAX  = 3'h4;

  // output codes
  localparam logic [23:0] FMT_MSB_FLIP = 24'h800000;

  // pipeline defaults
  localparam int BUF_DEPTH = 2;

  // coefficient selected on the serial coefficient port
  typedef enum logic [1:0] {
    SEL_SELF_OFFSET = 2'h0,
    SEL_SELF_GAIN   = 2'h1,
    SEL_SYS_OFFSET  = 2'h2,
    SEL_SYS_GAIN    = 2'h3
  } coef_sel_t;

endpackage

// ---- hw/sample_stream_if.sv ----
// valid/ready carrier for signed samples between correction stages
`timescale 1ns/100ps
`default_nettype none
interface sample_stream_if #(parameter int W = 24);
  logic                valid;
  logic                ready;
  logic signed [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- hw/cal_stage.sv ----
// one offset-subtract and gain-scale stage with its output register
`timescale 1ns/100ps
`default_nettype none
module cal_stage #(
  parameter int W    = 24,
  parameter int FRAC = 23
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // correction setup
  input  wire logic         offset_bypass,
  input  wire logic         gain_bypass,
  input  wire logic [W-1:0] offset_coeff,
  input  wire logic [W-1:0] gain_coeff,
  // samples
  sample_stream_if.snk      din,
  sample_stream_if.src      dout
);

  if (W < 8 || FRAC >= W) begin : g_bad_width
    $error("cal_stage: W must be at least 8 and FRAC below W");
  end

  localparam logic [W-1:0] UNITY = {{(W-1){1'b0}}, 1'b1} << FRAC;

  logic signed [W:0]     x_ext;
  logic signed [W:0]     off_ext;
  logic signed [W:0]     diff;
  logic signed [W+1:0]   gmul;
  logic signed [2*W+2:0] prod;
  logic signed [2*W+2:0] scaled;
  logic signed [2*W+2:0] pick;
  logic                  sat_hi;
  logic                  sat_lo;
  logic signed [W-1:0]   res;
  logic                  vld_q;
  logic signed [W-1:0]   data_q;

  assign x_ext   = {din.data[W-1], din.data};
  assign off_ext = {offset_coeff[W-1], offset_coeff};
  // a bypassed stage passes its input untouched
  assign diff    = offset_bypass ? x_ext : x_ext - off_ext;
  // coefficient spans -1..+1 around unity, i.e. 0x to nearly 2x
  assign gmul    = {2'b00, UNITY} + {{2{gain_coeff[W-1]}}, gain_coeff};
  assign prod    = diff * gmul;
  assign scaled  = prod >>> FRAC;
  assign pick    = gain_bypass ? {{(W+2){diff[W]}}, diff} : scaled;
  assign sat_hi  = pick > $signed({{(W+4){1'b0}}, {(W-1){1'b1}}});
  assign sat_lo  = pick < $signed({{(W+4){1'b1}}, {(W-1){1'b0}}});
  assign res     = sat_hi ? {1'b0, {(W-1){1'b1}}} :
                   sat_lo ? {1'b1, {(W-1){1'b0}}} : pick[W-1:0];

  assign din.ready  = ce & (~vld_q | dout.ready);
  assign dout.valid = vld_q;
  assign dout.data  = data_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vld_q  <= 1'b0;
      data_q <= '0;
    end else if (din.ready) begin
      vld_q <= din.valid;
      if (din.valid) begin
        data_q <= res;
      end
    end
  end

endmodule
`default_nettype wire

// ---- hw/adc_cal_path.sv ----
// conversion correction path: coefficients, two stages, format, result
//
// How it works
// - unipolar zero gives 0x000000, straight binary
// - bipolar zero/negative full scale per format
// - system offset 24-bit, serial MSB first
// - system offset kept until rewrite or calibration
// - system offset subtracted when bypass bit 0
// - system offset after self stage, before gain
// - system gain 24-bit, kept, serial MSB first
// - system gain applied when bypass bit 0
// - system gain scales up to 2x
// - self offset 24-bit, kept, serial MSB first
// - self offset subtracted when bypass bit 0
// - self offset is the first correction
// - self offset precedes unipolar 2x scale
// - self gain host write ignored during calibration
// - self gain applied before system corrections
// - self gain scales up to 2x
// - bipolar format bit: 0 twos, 1 offset
// - out-of-range results clamp to end codes
// - digital gain applied after all corrections
// - bypass bits exclude coefficients, reset to 1
`timescale 1ns/100ps
`default_nettype none
module adc_cal_path #(
  parameter int DATA_W = adc_cal_pkg::COEF_W,
  parameter int DEPTH  = adc_cal_pkg::BUF_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // range and format selection
  input  wire logic              unipolar_mode,
  input  wire logic              format_offset_binary,
  // calibration control register
  input  wire logic              ctrl_wr,
  input  wire logic [7:0]        ctrl_wdata,
  output logic [7:0]             calibration_control_reg,
  // serial coefficient access
  input  wire logic [1:0]        coef_sel,
  input  wire logic              coef_load,
  input  wire logic              coef_shift,
  input  wire logic              coef_sdi,
  input  wire logic              coef_commit,
  output logic                   coef_sdo,
  output logic                   write_ignored,
  // calibration engine
  input  wire logic              cal_active,
  input  wire logic              self_cal_done,
  input  wire logic [DATA_W-1:0] self_cal_offset,
  input  wire logic [DATA_W-1:0] self_cal_gain,
  input  wire logic              sys_cal_done,
  input  wire logic [DATA_W-1:0] sys_cal_offset,
  input  wire logic [DATA_W-1:0] sys_cal_gain,
  // raw filtered conversion results
  input  wire logic              raw_valid,
  input  wire logic [DATA_W-1:0] raw_data,
  output logic                   raw_ready,
  // corrected result
  output logic                   result_valid,
  output logic [DATA_W-1:0]      result_data,
  input  wire logic              result_ready
);

  if (DATA_W < 8) begin : g_bad_width
    $error("adc_cal_path: DATA_W must be at least 8");
  end
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("adc_cal_path: DEPTH must be a power of two, at least 2");
  end
  // the offset-binary flip is built from the package width
  if (DATA_W < adc_cal_pkg::COEF_W) begin : g_bad_coef_w
    $error("adc_cal_path: DATA_W below the coefficient width");
  end

  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int XW = DATA_W + 6;
  localparam logic [DATA_W-1:0] COEF_RST = DATA_W'(adc_cal_pkg::COEF_RST);
  localparam logic [DATA_W-1:0] MSB_FLIP =
    DATA_W'(adc_cal_pkg::FMT_MSB_FLIP) << (DATA_W - adc_cal_pkg::COEF_W);

  // ---------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic       self_off_byp;
  logic       self_gain_byp;
  logic       sys_off_byp;
  logic       sys_gain_byp;
  logic [2:0] digital_gain_select;

  assign self_off_byp  = ctrl_q[adc_cal_pkg::SELF_OFF_BYP];
  assign self_gain_byp = ctrl_q[adc_cal_pkg::SELF_GAIN_BYP];
  assign sys_off_byp   = ctrl_q[adc_cal_pkg::SYS_OFF_BYP];
  assign sys_gain_byp  = ctrl_q[adc_cal_pkg::SYS_GAIN_BYP];
  assign digital_gain_select =
    ctrl_q[adc_cal_pkg::GAIN_CODE_HI:adc_cal_pkg::GAIN_CODE_LO];
  assign calibration_control_reg = ctrl_q;

  // bypass bits come up set, so a fresh part passes raw data through
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= adc_cal_pkg::CTRL_RST;
    end else if (ce && ctrl_wr) begin
      ctrl_q <= ctrl_wdata & adc_cal_pkg::CTRL_WMASK;
    end
  end

  // ---------------------------------------------------------------------
  // coefficient registers and serial access
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] self_offset_coeff_q;
  logic [DATA_W-1:0] self_gain_coeff_q;
  logic [DATA_W-1:0] system_offset_coeff_q;
  logic [DATA_W-1:0] system_gain_coeff_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] coef_rd;
  logic              wr_self_off;
  logic              wr_self_gain;
  logic              wr_sys_off;
  logic              wr_sys_gain;
  logic              self_gain_blocked;
  logic              write_ignored_q;

  // the select code also steers the commit, so hold it through a write
  assign coef_rd =
    (coef_sel == adc_cal_pkg::SEL_SELF_OFFSET) ? self_offset_coeff_q :
    (coef_sel == adc_cal_pkg::SEL_SELF_GAIN)   ? self_gain_coeff_q :
    (coef_sel == adc_cal_pkg::SEL_SYS_OFFSET)  ? system_offset_coeff_q :
                                                 system_gain_coeff_q;

  assign wr_self_off  = coef_commit &&
                        coef_sel == adc_cal_pkg::SEL_SELF_OFFSET;
  assign wr_self_gain = coef_commit &&
                        coef_sel == adc_cal_pkg::SEL_SELF_GAIN;
  assign wr_sys_off   = coef_commit &&
                        coef_sel == adc_cal_pkg::SEL_SYS_OFFSET;
  assign wr_sys_gain  = coef_commit &&
                        coef_sel == adc_cal_pkg::SEL_SYS_GAIN;
  assign self_gain_blocked = wr_self_gain && cal_active;

  // the shifter sends its top bit first and takes new bits at the bottom
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_q <= COEF_RST;
    end else if (ce && coef_load) begin
      shift_q <= coef_rd;
    end else if (ce && coef_shift) begin
      shift_q <= {shift_q[DATA_W-2:0], coef_sdi};
    end
  end
  assign coef_sdo = shift_q[DATA_W-1];

  // a finishing calibration beats a host write in the same cycle, since
  // the measured value is what the calibration was run for
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      self_offset_coeff_q <= COEF_RST;
      self_gain_coeff_q   <= COEF_RST;
    end else if (ce && self_cal_done) begin
      self_offset_coeff_q <= self_cal_offset;
      self_gain_coeff_q   <= self_cal_gain;
    end else if (ce) begin
      if (wr_self_off) begin
        self_offset_coeff_q <= shift_q;
      end
      if (wr_self_gain && !self_gain_blocked) begin
        self_gain_coeff_q <= shift_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      system_offset_coeff_q <= COEF_RST;
      system_gain_coeff_q   <= COEF_RST;
    end else if (ce && sys_cal_done) begin
      system_offset_coeff_q <= sys_cal_offset;
      system_gain_coeff_q   <= sys_cal_gain;
    end else if (ce) begin
      if (wr_sys_off) begin
        system_offset_coeff_q <= shift_q;
      end
      if (wr_sys_gain) begin
        system_gain_coeff_q <= shift_q;
      end
    end
  end

  // a pulse for each refused write; held, like all state, while ce is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_ignored_q <= 1'b0;
    end else if (ce) begin
      write_ignored_q <= self_gain_blocked;
    end
  end
  assign write_ignored = write_ignored_q;

  // ---------------------------------------------------------------------
  // DEPTH-entry input buffer, two entries by default
  // ---------------------------------------------------------------------
  sample_stream_if #(.W(DATA_W)) buf_s ();
  sample_stream_if #(.W(DATA_W)) self_s ();
  sample_stream_if #(.W(DATA_W)) sys_s ();

  logic [DATA_W-1:0] buf_mem [DEPTH];
  logic [PW-1:0]     wr_ptr_q;
  logic [PW-1:0]     rd_ptr_q;
  logic [PW:0]       count_q;
  logic [PW:0]       count_d;
  logic              raw_ready_q;
  logic              push;
  logic              pop;

  // ready is registered, so a full buffer refuses on the very next cycle
  assign push    = ce && raw_valid && raw_ready_q;
  assign pop     = buf_s.valid && buf_s.ready;
  // the count is a bit wider than the pointers so full and empty differ
  assign count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
  assign buf_s.valid = count_q != '0;
  assign buf_s.data  = buf_mem[rd_ptr_q];
  assign raw_ready   = raw_ready_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      raw_ready_q <= 1'b0;
    end else if (ce) begin
      wr_ptr_q    <= wr_ptr_q + PW'(push);
      rd_ptr_q    <= rd_ptr_q + PW'(pop);
      count_q     <= count_d;
      raw_ready_q <= count_d != (PW+1)'(DEPTH);
    end
  end

  // no reset on the storage: only counted entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_q] <= raw_data;
    end
  end

  // ---------------------------------------------------------------------
  // correction stages: self-calibration first, system second
  // ---------------------------------------------------------------------
  cal_stage #(
    .W    (DATA_W),
    .FRAC (DATA_W - 1)
  ) u_self_stage (
    .clk           (clk),
    .rst_b         (rst_b),
    .ce            (ce),
    .offset_bypass (self_off_byp),
    .gain_bypass   (self_gain_byp),
    .offset_coeff  (self_offset_coeff_q),
    .gain_coeff    (self_gain_coeff_q),
    .din           (buf_s),
    .dout          (self_s)
  );

  cal_stage #(
    .W    (DATA_W),
    .FRAC (DATA_W - 1)
  ) u_sys_stage (
    .clk           (clk),
    .rst_b         (rst_b),
    .ce            (ce),
    .offset_bypass (sys_off_byp),
    .gain_bypass   (sys_gain_byp),
    .offset_coeff  (system_offset_coeff_q),
    .gain_coeff    (system_gain_coeff_q),
    .din           (self_s),
    .dout          (sys_s)
  );

  // ---------------------------------------------------------------------
  // range scale, digital gain, clamp and format
  // ---------------------------------------------------------------------
  logic [2:0]          gain_shift;
  logic [2:0]          total_shift;
  logic signed [XW-1:0] v_ext;
  logic signed [XW-1:0] v_scaled;
  logic                uni_lo;
  logic                uni_hi;
  logic                bip_lo;
  logic                bip_hi;
  logic [DATA_W-1:0]   uni_code;
  logic [DATA_W-1:0]   bip_code;
  logic [DATA_W-1:0]   fmt_code;
  logic                result_valid_q;
  logic [DATA_W-1:0]   result_q;

  // codes above the largest gain behave as gain 1
  assign gain_shift  =
    (digital_gain_select > adc_cal_pkg::GAIN_CODE_MAX) ?
    3'h0 : digital_gain_select;
  // unipolar doubles after both offsets have been removed
  assign total_shift = gain_shift + {2'b00, unipolar_mode};
  assign v_ext    = {{6{sys_s.data[DATA_W-1]}}, sys_s.data};
  assign v_scaled = v_ext <<< total_shift;

  assign uni_lo = v_scaled < 0;
  assign uni_hi = v_scaled > $signed({6'h00, {DATA_W{1'b1}}});
  assign bip_hi = v_scaled > $signed({7'h00, {(DATA_W-1){1'b1}}});
  assign bip_lo = v_scaled < $signed({7'h7f, {(DATA_W-1){1'b0}}});

  assign uni_code = uni_lo ? '0 :
                    uni_hi ? {DATA_W{1'b1}} :
                    v_scaled[DATA_W-1:0];
  assign bip_code = bip_lo ? {1'b1, {(DATA_W-1){1'b0}}} :
                    bip_hi ? {1'b0, {(DATA_W-1){1'b1}}} :
                    v_scaled[DATA_W-1:0];
  // range and format are read as a sample leaves the last stage, so
  // change them only while the path is empty
  assign fmt_code = unipolar_mode ? uni_code :
                    format_offset_binary ? (bip_code ^ MSB_FLIP) :
                    bip_code;

  // the result moves only when a sample leaves the last stage
  assign sys_s.ready = ce && (!result_valid_q || result_ready);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      result_valid_q <= 1'b0;
      result_q       <= '0;
    end else if (sys_s.ready) begin
      result_valid_q <= sys_s.valid;
      if (sys_s.valid) begin
        result_q <= fmt_code;
      end
    end
  end

  assign result_valid = result_valid_q;
  assign result_data  = result_q;

endmodule
`default_nettype wire

// ---- tb/adc_cal_path_checker.sv ----
// port assertions for the conversion correction path
`timescale 1ns/100ps
`default_nettype none
module adc_cal_path_checker #(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              ce,
  // control and coefficient port
  input wire logic              ctrl_wr,
  input wire logic [7:0]        ctrl_wdata,
  input wire logic [7:0]        calibration_control_reg,
  input wire logic [1:0]        coef_sel,
  input wire logic              coef_load,
  input wire logic              coef_shift,
  input wire logic              coef_commit,
  input wire logic              coef_sdo,
  input wire logic              write_ignored,
  input wire logic              cal_active,
  input wire logic              self_cal_done,
  // sample stream
  input wire logic              raw_valid,
  input wire logic              raw_ready,
  input wire logic              result_valid,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic              result_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    ce && raw_valid && raw_ready;
  endsequence
  sequence s_locked_commit;
    ce && coef_commit && cal_active && coef_sel == 2'h1 && !self_cal_done;
  endsequence
  AST_CTRL_WRITE: assert property (
    ce && ctrl_wr |=> calibration_control_reg == ($past(ctrl_wdata) & 8'hfe))
    else $error("control write not shown");
  AST_CTRL_HOLD: assert property (
    !(ce && ctrl_wr) |=> $stable(calibration_control_reg))
    else $error("control register changed unasked");
  AST_RESET_STATE: assert property (
    $rose(rst_b) |-> calibration_control_reg == 8'h1e && !coef_sdo
      && !raw_ready && !result_valid && !write_ignored)
    else $error("bad state after reset");
  AST_RESULT_HOLD: assert property (
    result_valid && !(result_ready && ce) |=> result_valid
      && $stable(result_data))
    else $error("result dropped or changed while waiting");
  AST_RESULT_BOUND: assert property (
    s_take ##0 !result_valid |-> ##[1:12] result_valid)
    else $error("no result after a sample");
  AST_IGNORED: assert property (
    s_locked_commit |=> write_ignored)
    else $error("locked write not flagged");
  AST_IGNORED_CAUSE: assert property (
    write_ignored |-> $past(coef_commit) && $past(cal_active)
      && $past(coef_sel) == 2'h1)
    else $error("ignored flag without cause");
  AST_SDO_STILL: assert property (
    !(ce && (coef_load || coef_shift)) |=> $stable(coef_sdo))
    else $error("serial output moved without shift");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(result_valid) && $stable(result_data)
      && $stable(raw_ready) && $stable(calibration_control_reg)
      && $stable(coef_sdo) && $stable(write_ignored))
    else $error("state moved while clock enable low");
endmodule
bind adc_cal_path adc_cal_path_checker #(.DATA_W(DATA_W)) i_checker (
  .clk(clk), .rst_b(rst_b), .ce(ce), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .calibration_control_reg(calibration_control_reg),
  .coef_sel(coef_sel), .coef_load(coef_load), .coef_shift(coef_shift),
  .coef_commit(coef_commit), .coef_sdo(coef_sdo),
  .write_ignored(write_ignored), .cal_active(cal_active),
  .self_cal_done(self_cal_done), .raw_valid(raw_valid),
  .raw_ready(raw_ready), .result_valid(result_valid),
  .result_data(result_data), .result_ready(result_ready));
`default_nettype wire

// ---- tb/host_model.sv ----
// host model for the control byte and the serial coefficient port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input  wire logic      clk,
  // control register
  output var logic       ctrl_wr,
  output var logic [7:0] ctrl_wdata,
  // serial coefficient port
  output var logic [1:0] coef_sel,
  output var logic       coef_load,
  output var logic       coef_shift,
  output var logic       coef_sdi,
  output var logic       coef_commit,
  input  wire logic      coef_sdo
);
  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    coef_sel = 2'h0;
    coef_load = 1'b0;
    coef_shift = 1'b0;
    coef_sdi = 1'b0;
    coef_commit = 1'b0;
  end
  // every task is entered and left just after a falling edge
  task automatic wr_ctrl(input logic [7:0] v);
    ctrl_wdata = v;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
    ctrl_wdata = ~v;
  endtask
  task automatic wr_coef(input logic [1:0] s, input logic [23:0] v);
    int i;
    coef_sel = s;
    for (i = 23; i >= 0; i--) begin
      coef_sdi = v[i];
      coef_shift = 1'b1;
      @(negedge clk);
    end
    // no shift in the commit cycle, the shifter must stay put
    coef_shift = 1'b0;
    coef_sdi = ~coef_sdi;
    coef_commit = 1'b1;
    @(negedge clk);
    coef_commit = 1'b0;
  endtask
  task automatic rd_coef(input logic [1:0] s, output logic [23:0] v);
    int i;
    coef_sel = s;
    coef_load = 1'b1;
    @(negedge clk);
    coef_load = 1'b0;
    for (i = 23; i >= 0; i--) begin
      v[i] = coef_sdo;
      coef_shift = (i > 0);
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/test_adc_cal_path.sv ----
// self-checking bench for the conversion correction path
`timescale 1ns/100ps
`default_nettype none
module test_adc_cal_path;
  logic        clk, rst_b, ce, unipolar_mode, format_offset_binary;
  logic        ctrl_wr, coef_load, coef_shift, coef_sdi, coef_commit;
  logic        coef_sdo, write_ignored, cal_active;
  logic        self_cal_done, sys_cal_done, raw_valid, raw_ready;
  logic        result_valid, result_ready;
  logic [1:0]  coef_sel;
  logic [7:0]  ctrl_wdata, calibration_control_reg;
  logic [23:0] self_cal_offset, self_cal_gain, sys_cal_offset, sys_cal_gain;
  logic [23:0] raw_data, result_data;
  logic [57:0] tbl [19];
  int          n_errors;
  int          compares;

  adc_cal_path i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .unipolar_mode(unipolar_mode),
    .format_offset_binary(format_offset_binary), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .calibration_control_reg(calibration_control_reg),
    .coef_sel(coef_sel), .coef_load(coef_load), .coef_shift(coef_shift),
    .coef_sdi(coef_sdi), .coef_commit(coef_commit), .coef_sdo(coef_sdo),
    .write_ignored(write_ignored), .cal_active(cal_active),
    .self_cal_done(self_cal_done), .self_cal_offset(self_cal_offset),
    .self_cal_gain(self_cal_gain), .sys_cal_done(sys_cal_done),
    .sys_cal_offset(sys_cal_offset), .sys_cal_gain(sys_cal_gain),
    .raw_valid(raw_valid), .raw_data(raw_data), .raw_ready(raw_ready),
    .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready));
  host_model i_host (
    .clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .coef_sel(coef_sel), .coef_load(coef_load), .coef_shift(coef_shift),
    .coef_sdi(coef_sdi), .coef_commit(coef_commit), .coef_sdo(coef_sdo));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bail;
    n_errors++;
    $display("wrong value at %0t: handshake timed out", $time);
    tally_and_finish();
  endtask
  task automatic push(input logic [23:0] d);
    int i;
    raw_data = d;
    raw_valid = 1'b1;
    for (i = 0; i < 40 && raw_ready !== 1'b1; i++) @(negedge clk);
    if (raw_ready !== 1'b1) bail();
    @(negedge clk);
    raw_valid = 1'b0;
    raw_data = ~d;
  endtask
  task automatic pop(input logic [23:0] exp);
    int i;
    result_ready = 1'b1;
    for (i = 0; i < 40 && result_valid !== 1'b1; i++) @(negedge clk);
    if (result_valid !== 1'b1) bail();
    chk(result_data, exp);
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [1:0] s, input logic [23:0] exp);
    logic [23:0] v;
    i_host.rd_coef(s, v);
    chk(v, exp);
  endtask

  initial begin
    logic [7:0]  c;
    logic [1:0]  uf;
    logic [23:0] rw, ex;
    int          i, n;
    // control, unipolar+format, raw sample, expected code
    tbl = '{{8'h1e, 2'b00, 24'h000005, 24'h000005},
            {8'h1e, 2'b00, 24'h800000, 24'h800000},
            {8'h1e, 2'b01, 24'h000000, 24'h800000},
            {8'h1e, 2'b01, 24'h800000, 24'h000000},
            {8'h1e, 2'b10, 24'h000000, 24'h000000},
            {8'h1e, 2'b10, 24'hfffff0, 24'h000000},
            {8'h1e, 2'b10, 24'h7fffff, 24'hfffffe},
            {8'h1c, 2'b00, 24'h00000a, 24'h000006},
            {8'h16, 2'b00, 24'h00000a, 24'h000007},
            {8'h1a, 2'b00, 24'h00000a, 24'h00000f},
            {8'h00, 2'b00, 24'h00000a, 24'h000009},
            {8'h20, 2'b00, 24'h00000a, 24'h000012},
            {8'h80, 2'b00, 24'h00000a, 24'h000090},
            {8'ha0, 2'b00, 24'h00000a, 24'h000009},
            {8'h00, 2'b10, 24'h00000a, 24'h000012},
            {8'h9e, 2'b00, 24'h100000, 24'h7fffff},
            {8'h9e, 2'b00, 24'hf00000, 24'h800000},
            {8'h3e, 2'b10, 24'h400000, 24'hffffff},
            {8'h7e, 2'b00, 24'h000003, 24'h000018}};
    {rst_b, unipolar_mode, format_offset_binary, cal_active} = 4'h0;
    {self_cal_done, sys_cal_done, raw_valid, result_ready} = 4'h0;
    {self_cal_offset, self_cal_gain, sys_cal_offset, sys_cal_gain} = '0;
    raw_data = 24'h000000;
    ce = 1'b1;
    n_errors = 0;
    compares = 0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk({16'h0000, calibration_control_reg}, 24'h00001e);
    for (i = 0; i < 4; i++) rd_chk(2'(i), 24'h000000);
    i_host.wr_ctrl(8'hff);
    chk({16'h0000, calibration_control_reg}, 24'h0000fe);
    // self offset 4, self gain 1.5x, system offset 3, system gain 1.5x
    i_host.wr_coef(2'h0, 24'h000004);
    i_host.wr_coef(2'h1, 24'h400000);
    i_host.wr_coef(2'h2, 24'h000003);
    i_host.wr_coef(2'h3, 24'h400000);
    rd_chk(2'h0, 24'h000004);
    rd_chk(2'h3, 24'h400000);
    for (i = 0; i < 19; i++) begin
      {c, uf, rw, ex} = tbl[i];
      i_host.wr_ctrl(c);
      {unipolar_mode, format_offset_binary} = uf;
      push(rw);
      pop(ex);
    end
    // receiver stalls until the path refuses, then drains in order
    i_host.wr_ctrl(8'h1e);
    {unipolar_mode, format_offset_binary} = 2'b00;
    result_ready = 1'b0;
    for (n = 0; n < 10 && raw_ready === 1'b1; n++) begin
      raw_data = 24'h000100 + 24'(n);
      raw_valid = 1'b1;
      @(negedge clk);
    end
    raw_valid = 1'b0;
    chk({23'h0, raw_ready}, 24'h000000);
    // a write offered while the clock enable is low must not land
    ce = 1'b0;
    i_host.wr_ctrl(8'h00);
    ce = 1'b1;
    chk({16'h0000, calibration_control_reg}, 24'h00001e);
    for (i = 0; i < n; i++) pop(24'h000100 + 24'(i));
    repeat (8) @(negedge clk);
    chk({23'h0, result_valid}, 24'h000000);
    // calibration results replace coefficients; locked self gain write
    cal_active = 1'b1;
    {self_cal_offset, self_cal_gain} = {24'h800111, 24'h000222};
    self_cal_done = 1'b1;
    @(negedge clk);
    self_cal_done = 1'b0;
    i_host.wr_coef(2'h1, 24'h123456);
    chk({23'h0, write_ignored}, 24'h000001);
    i_host.wr_coef(2'h2, 24'h654321);
    chk({23'h0, write_ignored}, 24'h000000);
    cal_active = 1'b0;
    rd_chk(2'h0, 24'h800111);
    rd_chk(2'h1, 24'h000222);
    rd_chk(2'h2, 24'h654321);
    {sys_cal_offset, sys_cal_gain} = {24'h000333, 24'hfff444};
    sys_cal_done = 1'b1;
    @(negedge clk);
    sys_cal_done = 1'b0;
    rd_chk(2'h2, 24'h000333);
    rd_chk(2'h3, 24'hfff444);
    tally_and_finish();
  end
endmodule
`default_nettype wire
